//--- joint_module_error_status.sv
// Purpose: Error byte and indicator supervision of one joint motor module
// Assumes: Command strobes arrive decoded, one cycle wide
// Notes:   Fault flags latch until an error reset command
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module joint_module_error_status
  import joint_status_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       clk_en,
  input  wire joint_cmd_t                 cmd,
  input  wire joint_evt_t                 evt,
  input  wire logic                       proto_v2,
  input  wire logic [2:0]                 joint_index,
  input  wire logic [POS_W_V2-1:0]        setpoint_pos,
  input  wire logic [POS_W_V2-1:0]        measured_pos,
  input  wire logic [CUR_W-1:0]           measured_current,
  input  wire logic                       enc_chan_a,
  input  wire logic                       enc_chan_b,
  input  wire logic [GAP_W-1:0]           command_gap_limit,
  input  wire logic [POS_W_V2-1:0]        following_error_limit,
  input  wire logic [CUR_W-1:0]           current_limit,
  output logic [7:0]                      joint_error_status_byte,
  output logic                            motor_ready,
  output logic [10:0]                     answer_id,
  output logic                            base_led,
  output logic                            module_led
);

  //////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  logic quad_fault;
  logic blink;

  quad_seq_check u_quad (
    .clk       (clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .chan_a    (enc_chan_a),
    .chan_b    (enc_chan_b),
    .seq_fault (quad_fault)
  );

  blink_gen u_blink (
    .clk         (clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .half_period (BLINK_HALF_DEF),
    .blink       (blink)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Position compare

  logic [POS_W_V2-1:0] set_ext;
  logic [POS_W_V2-1:0] meas_ext;
  logic                lag_over;

  always_comb
  begin
    set_ext  = {{(POS_W_V2-POS_W_V1){setpoint_pos[POS_W_V1-1]}}, setpoint_pos[POS_W_V1-1:0]};
    meas_ext = {{(POS_W_V2-POS_W_V1){measured_pos[POS_W_V1-1]}}, measured_pos[POS_W_V1-1:0]};
    if (proto_v2)
    begin
      set_ext  = setpoint_pos;
      meas_ext = measured_pos;
    end
    lag_over = abs_diff(meas_ext, set_ext) > following_error_limit;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command gap counter

  logic [GAP_W-1:0] gap_q;
  logic [GAP_W-1:0] gap_d;
  logic             gap_over;

  always_comb
  begin
    gap_d = gap_q;
    if (cmd.setpoint_cmd)
      gap_d = '0;
    else if (gap_q != {GAP_W{1'b1}})
      gap_d = gap_q + GAP_W'(1);
    gap_over = gap_q > command_gap_limit;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      gap_q <= '0;
    else if (clk_en)
      gap_q <= gap_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error flags and state

  logic [7:0]   err_q;
  logic [7:0]   err_d;
  joint_state_t st_q;
  joint_state_t st_d;
  logic         ready_q;
  logic         ready_d;
  logic         faults;

  always_comb
  begin
    err_d   = err_q;
    st_d    = st_q;
    if (cmd.error_reset_cmd)
    begin
      err_d = ERR_AFTER_RESET;
      st_d  = ST_FAULTED;
    end
    else if (cmd.enable_cmd && (err_q & ~ERR_AFTER_RESET) == ERR_READY)
    begin
      err_d[FLAG_DISABLED_BIT] = 1'b0;
      st_d = ST_READY;
    end
    // Set wins over clear; bit n-1 holds flag n
    // Restart event
    if (evt.restart_event)
      err_d[FLAG_RESTART_BIT] = 1'b1;
    if (gap_over && !cmd.setpoint_cmd)
      err_d[FLAG_CMD_GAP_BIT] = 1'b1;
    if (lag_over)
      err_d[FLAG_LAG_BIT] = 1'b1;
    if (quad_fault)
      err_d[FLAG_QUAD_BIT] = 1'b1;
    if (measured_current > current_limit)
      err_d[FLAG_OC_BIT] = 1'b1;
    if (evt.can_error)
      err_d[FLAG_CAN_BIT] = 1'b1;
    faults = (err_d & ~ERR_AFTER_RESET) != ERR_READY;
    // Any fault disables the motor
    if (faults)
    begin
      err_d[FLAG_DISABLED_BIT] = 1'b1;
      st_d = ST_FAULTED;
    end
    err_d[FLAG_UNUSED_BIT] = 1'b0;
    // Ready only at zero error byte
    ready_d = (st_d == ST_READY) && (err_d == ERR_READY);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      err_q   <= ERR_STARTUP_VALUE;
      st_q    <= ST_STARTUP;
      ready_q <= 1'b0;
    end
    else if (clk_en)
    begin
      err_q   <= err_d;
      st_q    <= st_d;
      ready_q <= ready_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Identifier and indicators

  logic [10:0] id_q;
  logic [10:0] id_d;
  logic        base_q;
  logic        base_d;
  logic        mod_q;
  logic        mod_d;

  always_comb
  begin
    id_d = joint_id(joint_index);
    if (joint_index == 3'h0 || joint_index > JOINT_INDEX_MAX)
      id_d = JOINT_ID_STEP;
    base_d = evt.power_good && (evt.can_traffic ? blink : 1'b1);
    mod_d  = evt.power_good && blink;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      id_q   <= JOINT_ID_STEP;
      base_q <= 1'b0;
      mod_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      id_q   <= id_d;
      base_q <= base_d;
      mod_q  <= mod_d;
    end
  end

  assign joint_error_status_byte = err_q;
  assign motor_ready             = ready_q;
  assign answer_id               = id_q;
  assign base_led                = base_q;
  assign module_led              = mod_q;

endmodule

//--- joint_status_pkg.sv
// Purpose: Shared constants and types for joint module error supervision
// Assumes: Single 200 MHz clock domain
// Notes:   Flag n of the error byte sits at bit n-1
package joint_status_pkg;

  // Error byte flag positions
  localparam int unsigned FLAG_RESTART_BIT  = 0;
  localparam int unsigned FLAG_UNUSED_BIT   = 1;
  localparam int unsigned FLAG_DISABLED_BIT = 2;
  localparam int unsigned FLAG_CMD_GAP_BIT  = 3;
  localparam int unsigned FLAG_LAG_BIT      = 4;
  localparam int unsigned FLAG_QUAD_BIT     = 5;
  localparam int unsigned FLAG_OC_BIT       = 6;
  localparam int unsigned FLAG_CAN_BIT      = 7;

  // Error byte values
  localparam logic [7:0] ERR_STARTUP_VALUE  = 8'h1c;
  localparam logic [7:0] ERR_AFTER_RESET    = 8'h04;
  localparam logic [7:0] ERR_READY          = 8'h00;

  // Joint identifiers on the field bus
  localparam logic [10:0] JOINT_ID_STEP     = 11'h010;
  localparam logic [2:0]  JOINT_INDEX_MAX   = 3'h6;

  // Position widths per protocol version, current and gap counter widths
  localparam int unsigned POS_W_V1          = 16;
  localparam int unsigned POS_W_V2          = 32;
  localparam int unsigned CUR_W             = 16;
  localparam int unsigned GAP_W             = 24;

  // Indicator blink timing
  localparam int unsigned BLINK_HALF_MS     = 250;
  localparam int unsigned CLK_MHZ           = 200;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_W           = 26;
  localparam logic [BLINK_W-1:0] BLINK_HALF_DEF = BLINK_W'(BLINK_HALF_CYCLES);

  // Command strobes from the bus frame decoder
  typedef struct packed {
    logic setpoint_cmd;
    logic enable_cmd;
    logic error_reset_cmd;
  } joint_cmd_t;

  // Fault events, bus traffic and power good status inputs
  typedef struct packed {
    logic        restart_event;
    logic        can_error;
    logic        can_traffic;
    logic        power_good;
  } joint_evt_t;

  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_FAULTED = 2'b01,
    ST_READY   = 2'b11
  } joint_state_t;

  // Absolute difference of two signed positions
  function automatic logic [POS_W_V2-1:0] abs_diff(input logic signed [POS_W_V2-1:0] a,
                                                    input logic signed [POS_W_V2-1:0] b);
    logic signed [POS_W_V2:0] d;
    d = {a[POS_W_V2-1], a} - {b[POS_W_V2-1], b};
    abs_diff = d[POS_W_V2] ? POS_W_V2'(-d) : d[POS_W_V2-1:0];
  endfunction

  // Joint identifier for joint index 1..6
  function automatic logic [10:0] joint_id(input logic [2:0] idx);
    joint_id = JOINT_ID_STEP * 11'(idx);
  endfunction

endpackage

//--- quad_seq_check.sv
// Purpose: Quadrature channel order checker
// Assumes: Channels are synchronous to clk
// Notes:   Flags a jump of two Gray steps in one sample
`timescale 1ns/1ps
module quad_seq_check
  import joint_status_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic chan_a,
  input  wire logic chan_b,
  output logic      seq_fault
);

  logic [1:0] prev_q;
  logic [1:0] prev_d;
  logic       fault_q;
  logic       fault_d;

  always_comb
  begin
    prev_d  = {chan_a, chan_b};
    // Both channels changing at once is not a legal step
    fault_d = ((prev_q ^ {chan_a, chan_b}) == 2'b11);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_q  <= 2'b00;
      fault_q <= 1'b0;
    end
    else if (clk_en)
    begin
      prev_q  <= prev_d;
      fault_q <= fault_d;
    end
  end

  assign seq_fault = fault_q;

endmodule

//--- blink_gen.sv
// Purpose: Square wave for status indicators
// Assumes: Half period given in clock cycles
// Notes:   Runs whenever the clock enable is high
`timescale 1ns/1ps
module blink_gen
  import joint_status_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               clk_en,
  input  wire logic [BLINK_W-1:0] half_period,
  output logic                    blink
);

  logic [BLINK_W-1:0] cnt_q;
  logic [BLINK_W-1:0] cnt_d;
  logic               blink_q;
  logic               blink_d;

  always_comb
  begin
    cnt_d   = cnt_q + BLINK_W'(1);
    blink_d = blink_q;
    if (cnt_q >= half_period - BLINK_W'(1))
    begin
      cnt_d   = '0;
      blink_d = ~blink_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q   <= '0;
      blink_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q   <= cnt_d;
      blink_q <= blink_d;
    end
  end

  assign blink = blink_q;

endmodule

//--- joint_status_checker.sv
// Purpose: Assertions on the error status block
// Assumes: One clock, async active low reset
// Notes:   Bound to the block from tb_top
`timescale 1ns/1ps
module joint_status_checker
  import joint_status_pkg::*;
(
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             clk_en,
  input wire joint_cmd_t       cmd,
  input wire joint_evt_t       evt,
  input wire logic [2:0]       joint_index,
  input wire logic [CUR_W-1:0] measured_current,
  input wire logic [CUR_W-1:0] current_limit,
  input wire logic             enc_chan_a,
  input wire logic             enc_chan_b,
  input wire logic [7:0]       joint_error_status_byte,
  input wire logic             motor_ready,
  input wire logic [10:0]      answer_id
);
  wire logic [7:0] eb  = joint_error_status_byte;
  wire logic [7:0] flt = joint_error_status_byte & 8'hf9;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////////
  property p_unused; eb[1] == 1'b0; endproperty
  a_unused: assert property (p_unused)
    else $error("unused flag set");
  property p_restart; clk_en && evt.restart_event |=> eb[0]; endproperty
  a_restart: assert property (p_restart)
    else $error("restart flag missing");
  property p_can; clk_en && evt.can_error |=> eb[7]; endproperty
  a_can: assert property (p_can)
    else $error("bus error flag missing");
  property p_oc; clk_en && (measured_current > current_limit) |=> eb[6]; endproperty
  a_oc: assert property (p_oc)
    else $error("overcurrent flag missing");
  property p_quad;
    clk_en && $changed(enc_chan_a) && $changed(enc_chan_b) |-> ##[1:3] eb[5];
  endproperty
  a_quad: assert property (p_quad)
    else $error("quadrature flag missing");
  property p_latch;
    clk_en && !cmd.error_reset_cmd |=> (flt & $past(flt)) == $past(flt);
  endproperty
  a_latch: assert property (p_latch)
    else $error("fault flag dropped");
  property p_ready; motor_ready |-> eb == 8'h00; endproperty
  a_ready: assert property (p_ready)
    else $error("ready with flags set");
  property p_id;
    clk_en && joint_index inside {[3'h1:3'h6]} |=> answer_id == {4'h0, $past(joint_index), 4'h0};
  endproperty
  a_id: assert property (p_id)
    else $error("wrong answer id");
  cover property (cmd.enable_cmd ##1 motor_ready);
  cover property (cmd.error_reset_cmd ##1 eb == 8'h04);
  cover property (eb[5]);
endmodule

//--- host_model.sv
// Purpose: Host that sends setpoints and commands
// Assumes: Commands are one cycle strobes
// Notes:   Setpoint tracks measured position
`timescale 1ns/1ps
module host_model
  import joint_status_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hold_off,
  input  wire logic [1:0]  req,
  input  wire logic [31:0] measured_pos,
  output joint_cmd_t       cmd,
  output logic [31:0]      setpoint_pos
);
  logic [2:0] tick_q;
  //////////////////////////////////////////////////////////////////////////////
  // Regular setpoints in reach
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_q       <= 3'h0;
      cmd          <= '0;
      setpoint_pos <= 32'h0;
    end
    else
    begin
      tick_q              <= hold_off ? tick_q : tick_q + 3'h1;
      cmd.setpoint_cmd    <= !hold_off && (tick_q == 3'h7);
      cmd.error_reset_cmd <= (req == 2'h1);
      cmd.enable_cmd      <= (req == 2'h2);
      if (!hold_off && tick_q == 3'h7)
        setpoint_pos <= measured_pos;
    end
  end
endmodule

//--- tb_top.sv
// Purpose: Self-checking bench of the error status block
// Assumes: 200 MHz clock
// Notes:   Expected values queued, compared by a monitor
`timescale 1ns/1ps
module tb_top
  import joint_status_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, proto_v2 = 1'b0;
  logic hold_off = 1'b0, enc_chan_a = 1'b0, enc_chan_b = 1'b0;
  logic base_led, module_led, motor_ready;
  logic [1:0] req = 2'h0;
  logic [2:0] joint_index = 3'h1;
  logic [7:0] joint_error_status_byte;
  logic [10:0] answer_id;
  logic [11:0] exp_q[$], e;
  logic [15:0] measured_current = 16'h0, current_limit = 16'h1000;
  logic [23:0] command_gap_limit = 24'd40;
  logic [31:0] measured_pos, setpoint_pos, following_error_limit = 32'h64;
  logic [31:0] rnd = 32'h62975e4c;
  logic [7:0] flags [6] = '{8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  joint_evt_t evt = 4'b0001;
  joint_cmd_t cmd;
  int mismatches = 0, compares = 0;
  event look;
  joint_module_error_status dut (.*);
  host_model host (.clk(clk), .reset_n(reset_n), .hold_off(hold_off), .req(req),
    .measured_pos(measured_pos), .cmd(cmd), .setpoint_pos(setpoint_pos));
  //////////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic expect_v(input logic [11:0] v);
    exp_q.push_back(v);
    -> look;
  endtask
  task automatic status(input logic [7:0] b, input logic r);
    expect_v({3'b001, r, b});
  endtask
  task automatic pulse(input logic [1:0] k);
    rnd = lfsr(rnd);
    measured_current = {4'h0, rnd[11:0]};
    proto_v2 = rnd[31];
    req = k;
    step();
    req = 2'h0;
    step();
  endtask
  task automatic check(input logic [10:0] ev, input logic [10:0] gv);
    compares++;
    if (gv !== ev)
    begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, ev, gv);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial forever
  begin
    @(look);
    e = exp_q.pop_front();
    if (e[11])
      check(e[10:0], answer_id);
    else
      check(e[10:0], {module_led, base_led, motor_ready, joint_error_status_byte});
  end
  initial
  begin
    step(20000);
    mismatches++;
    test_done();
  end
  initial
  begin
    measured_pos = rnd;
    step(5);
    reset_n = 1'b1;
    step();
    status(8'h1c, 1'b0);
    step(10);
    pulse(2'h1);
    status(8'h04, 1'b0);
    pulse(2'h2);
    status(8'h00, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      case (i)
        0: evt.restart_event = 1'b1;
        1: hold_off = 1'b1;
        2: {hold_off, measured_pos} = {1'b1, setpoint_pos + 32'd101};
        3: {enc_chan_a, enc_chan_b} = 2'b11;
        4: measured_current = 16'h1001;
        default: evt.can_error = 1'b1;
      endcase
      step(i == 1 ? 45 : 2);
      {evt.restart_event, evt.can_error, hold_off, enc_chan_b} = 4'h0;
      measured_pos = setpoint_pos;
      measured_current = 16'h0;
      step();
      enc_chan_a = 1'b0;
      step(10);
      status(flags[i] | 8'h04, 1'b0);
      pulse(2'h2);
      status(flags[i] | 8'h04, 1'b0);
      pulse(2'h1);
      status(8'h04, 1'b0);
      pulse(2'h2);
      status(8'h00, 1'b1);
    end
    for (int k = 0; k < 8; k++)
    begin
      joint_index = 3'(k);
      step(2);
      expect_v({1'b1, (k inside {[1:6]}) ? {4'h0, 3'(k), 4'h0} : 11'h010});
    end
    evt.power_good = 1'b0;
    step(2);
    expect_v({4'b0001, 8'h00});
    step();
    test_done();
  end
endmodule
bind joint_module_error_status joint_status_checker chk (.*);
